/* design/dpp_pkg.sv */
// Constants, register map and control-line modes of the dual parallel port.
package dpp_pkg;
  localparam int unsigned PORT_W = 8;
  localparam int unsigned SYNC_W = 20;
  localparam logic [3:0] REG_PORT_B = 4'h0;
  localparam logic [3:0] REG_PORT_A = 4'h1;
  localparam logic [3:0] REG_DIR_B = 4'h2;
  localparam logic [3:0] REG_DIR_A = 4'h3;
  localparam logic [3:0] REG_AUX = 4'hB;
  localparam logic [3:0] REG_CTRL = 4'hC;
  localparam logic [3:0] REG_FLAGS = 4'hD;
  localparam logic [3:0] REG_ENABLE = 4'hE;
  localparam logic [3:0] REG_PORT_A_QUIET = 4'hF;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam int unsigned AUX_LATCH_A = 0;
  localparam int unsigned AUX_LATCH_B = 1;
  localparam int unsigned AUX_SHIFT_LO = 2;
  localparam int unsigned AUX_TIMER_OUT = 7;
  localparam int unsigned CTRL_CA1_EDGE = 0;
  localparam int unsigned CTRL_CA2_LO = 1;
  localparam int unsigned CTRL_CB1_EDGE = 4;
  localparam int unsigned CTRL_CB2_LO = 5;
  localparam int unsigned FLAG_CA2 = 0;
  localparam int unsigned FLAG_CA1 = 1;
  localparam int unsigned FLAG_CB2 = 3;
  localparam int unsigned FLAG_CB1 = 4;
  localparam int unsigned FLAG_ANY = 7;
  localparam int unsigned ENABLE_SET = 7;
  localparam int unsigned TIMER_PIN = 7;
  localparam int unsigned COUNT_PIN = 6;
  localparam logic [6:0] FLAG_MASK = 7'h1B;
  typedef enum logic [2:0] {
    CM_IN_NEG,
    CM_IN_NEG_IND,
    CM_IN_POS,
    CM_IN_POS_IND,
    CM_HANDSHAKE,
    CM_PULSE,
    CM_LOW,
    CM_HIGH
  } dpp_ctl_mode_t;
endpackage

/* design/dpp_sync.sv */
// Two-stage synchroniser for pins and control lines.
`timescale 1ns/1ns
module dpp_sync #(
  parameter int unsigned W = 8
) (
  input wire logic clock_i, // System clock.
  input wire logic rst_i, // Synchronous reset, active high.
  input wire logic ce_i, // Clock enable.
  input wire logic [W-1:0] d_i, // Raw levels.
  output logic [W-1:0] q_o // Synchronised levels.
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  always_comb begin
    meta_nxt = meta_r;
    q_nxt = q_r;
    if (ce_i) begin
      meta_nxt = d_i;
      q_nxt = meta_r;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      meta_r <= '0;
      q_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      q_r <= q_nxt;
    end
  end

  assign q_o = q_r;
endmodule

/* design/dpp_port.sv */
// One 8-bit port: direction, output and latched input registers.
`timescale 1ns/1ns
module dpp_port #(
  parameter int unsigned W = 8,
  parameter bit READ_OUT_REG = 1'b0
) (
  input wire logic clock_i, // System clock.
  input wire logic rst_i, // Synchronous reset, active high.
  input wire logic ce_i, // Clock enable.
  input wire logic [W-1:0] pin_i, // Synchronised pin levels.
  input wire logic edge_i, // Active strobe edge, one cycle.
  input wire logic latch_en_i, // Input latching enabled.
  input wire logic wr_out_i, // Write output bits.
  input wire logic wr_dir_i, // Write direction bits.
  input wire logic [W-1:0] wdata_i, // Write data.
  input wire logic rd_done_i, // Latched value has been read.
  output logic [W-1:0] dir_o, // Direction bits, one is output.
  output logic [W-1:0] out_o, // Output bits.
  output logic [W-1:0] rdata_o // Value seen by a read.
);
  logic [W-1:0] dir_r;
  logic [W-1:0] dir_nxt;
  logic [W-1:0] out_r;
  logic [W-1:0] out_nxt;
  logic [W-1:0] cap_r;
  logic [W-1:0] cap_nxt;
  logic held_r;
  logic held_nxt;

  always_comb begin
    dir_nxt = dir_r;
    out_nxt = out_r;
    cap_nxt = cap_r;
    held_nxt = held_r;
    if (ce_i) begin
      if (wr_dir_i) begin
        dir_nxt = wdata_i;
      end
      if (wr_out_i) begin
        out_nxt = wdata_i;
      end
      if (latch_en_i && edge_i) begin
        cap_nxt = pin_i;
        held_nxt = 1'b1;
      end else if (rd_done_i) begin
        held_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      dir_r <= '0;
      out_r <= '0;
      cap_r <= '0;
      held_r <= 1'b0;
    end else begin
      dir_r <= dir_nxt;
      out_r <= out_nxt;
      cap_r <= cap_nxt;
      held_r <= held_nxt;
    end
  end

  for (genvar gi = 0; gi < W; gi++) begin : g_bit
    assign rdata_o[gi] = (READ_OUT_REG && dir_r[gi]) ? out_r[gi] :
      (latch_en_i && held_r) ? cap_r[gi] : pin_i[gi];
  end

  assign dir_o = dir_r;
  assign out_o = out_r;

  chk_latch_capture: assert property (
    @(posedge clock_i) disable iff (rst_i)
    ce_i && latch_en_i && edge_i ##1 latch_en_i
    |-> cap_r == $past(pin_i) && held_r)
    else $error("strobe edge did not capture pins");

  chk_out_hidden: assert property (
    @(posedge clock_i) disable iff (rst_i)
    ce_i && wr_out_i && !wr_dir_i
    |=> out_r == $past(wdata_i) && dir_r == $past(dir_r))
    else $error("output write disturbed direction or was lost");
endmodule

/* design/dpp_top.sv */
// Dual parallel port: register decode, handshake lines, flags, pins.
`timescale 1ns/1ns
module dpp_top (
  input wire logic clock_i, // System clock, 25 MHz.
  input wire logic rst_i, // Synchronous reset, active high.
  input wire logic ce_i, // Clock enable, freezes all state when low.
  input wire logic select_active_high_i, // Chip select, active high.
  input wire logic select_active_low_n_i, // Chip select, active low.
  input wire logic rw_i, // High read, low write.
  input wire logic [3:0] register_select_lines_i, // Register index.
  input wire logic [7:0] data_i, // Write data from processor.
  output logic [7:0] data_o, // Read data to processor.
  output logic data_oe_o, // High while read data is driven.
  input wire logic [7:0] first_port_lines_i, // Port A pin levels.
  output logic [7:0] first_port_lines_o, // Port A pin drive.
  output logic [7:0] first_port_lines_oe_o, // Port A drive enables.
  input wire logic [7:0] second_port_lines_i, // Port B pin levels.
  output logic [7:0] second_port_lines_o, // Port B pin drive.
  output logic [7:0] second_port_lines_oe_o, // Port B drive enables.
  input wire logic first_port_strobe_in_i, // Port A strobe input.
  input wire logic first_port_handshake_line_i, // Port A handshake in.
  output logic first_port_handshake_line_o, // Port A handshake out.
  output logic first_port_handshake_line_oe_o, // Port A handshake enable.
  input wire logic second_port_strobe_line_i, // Port B strobe in.
  output logic second_port_strobe_line_o, // Port B strobe out.
  output logic second_port_strobe_line_oe_o, // Port B strobe enable.
  input wire logic second_port_handshake_line_i, // Port B handshake in.
  output logic second_port_handshake_line_o, // Port B handshake out.
  output logic second_port_handshake_line_oe_o, // Port B handshake enable.
  input wire logic timer_level_i, // Timer level for port B bit 7.
  output logic pulse_count_o, // Falling edge seen on port B bit 6.
  input wire logic serial_clk_out_i, // Shift clock to drive out.
  input wire logic serial_data_out_i, // Shift data to drive out.
  output logic serial_clk_in_o, // Synchronised port B strobe line.
  output logic serial_data_in_o, // Synchronised port B handshake line.
  output logic irq_n_o, // Interrupt drive level, always low.
  output logic irq_oe_o // Pulls interrupt line low while high.
);
  logic sel;
  logic rd;
  logic wr;
  logic hit_a;
  logic hit_a_any;
  logic hit_b;
  logic [3:0] ctl_raw;
  logic [dpp_pkg::SYNC_W-1:0] sync_q;
  logic [7:0] pa_s;
  logic [7:0] pb_s;
  logic [3:0] ctl_s;
  logic [3:0] ctl_d_r;
  logic [3:0] ctl_d_nxt;
  logic pb6_d_r;
  logic pb6_d_nxt;
  logic [1:0] fill_r;
  logic [1:0] fill_nxt;
  logic live;
  logic [3:0] rise;
  logic [3:0] fall;
  logic ca1_edge;
  logic cb1_edge;
  logic ca2_edge;
  logic cb2_edge;
  dpp_pkg::dpp_ctl_mode_t ca2_mode;
  dpp_pkg::dpp_ctl_mode_t cb2_mode;
  logic ca2_is_out;
  logic cb2_is_out;
  logic shift_on;
  logic [7:0] aux_r;
  logic [7:0] aux_nxt;
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic [6:0] flags_r;
  logic [6:0] flags_nxt;
  logic [6:0] enable_r;
  logic [6:0] enable_nxt;
  logic [6:0] flag_set;
  logic [6:0] flag_clr;
  logic ca2_lvl_r;
  logic ca2_lvl_nxt;
  logic cb2_lvl_r;
  logic cb2_lvl_nxt;
  logic cb1_lvl_r;
  logic cb1_lvl_nxt;
  logic timer_lvl_r;
  logic timer_lvl_nxt;
  logic [7:0] data_r;
  logic [7:0] data_nxt;
  logic data_oe_r;
  logic data_oe_nxt;
  logic irq_any;
  logic [7:0] pa_dir;
  logic [7:0] pa_out;
  logic [7:0] pa_rd;
  logic [7:0] pb_dir;
  logic [7:0] pb_out;
  logic [7:0] pb_rd;

  assign sel = select_active_high_i && !select_active_low_n_i;
  assign rd = ce_i && sel && rw_i;
  assign wr = ce_i && sel && !rw_i;
  assign hit_a = register_select_lines_i == dpp_pkg::REG_PORT_A;
  assign hit_a_any = hit_a ||
    register_select_lines_i == dpp_pkg::REG_PORT_A_QUIET;
  assign hit_b = register_select_lines_i == dpp_pkg::REG_PORT_B;

  assign ctl_raw = {second_port_handshake_line_i,
    second_port_strobe_line_i, first_port_handshake_line_i,
    first_port_strobe_in_i};

  dpp_sync #(
    .W(dpp_pkg::SYNC_W)
  ) u_sync (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .d_i({ctl_raw, second_port_lines_i, first_port_lines_i}),
    .q_o(sync_q)
  );

  assign pa_s = sync_q[7:0];
  assign pb_s = sync_q[15:8];
  assign ctl_s = sync_q[19:16];

  always_comb begin
    ctl_d_nxt = ctl_d_r;
    pb6_d_nxt = pb6_d_r;
    fill_nxt = fill_r;
    if (ce_i) begin
      ctl_d_nxt = ctl_s;
      pb6_d_nxt = pb_s[dpp_pkg::COUNT_PIN];
      if (!live) begin
        fill_nxt = fill_r + 2'h1;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ctl_d_r <= '0;
      pb6_d_r <= 1'b0;
      fill_r <= '0;
    end else begin
      ctl_d_r <= ctl_d_nxt;
      pb6_d_r <= pb6_d_nxt;
      fill_r <= fill_nxt;
    end
  end

  // Edges stay masked until the delay flop holds a real pin sample.
  // Otherwise the reset zeros filling with idle-high levels look like edges.
  assign live = &fill_r;
  assign rise = live ? (ctl_s & ~ctl_d_r) : 4'h0;
  assign fall = live ? (~ctl_s & ctl_d_r) : 4'h0;
  assign ca2_mode = dpp_pkg::dpp_ctl_mode_t'(
    ctrl_r[dpp_pkg::CTRL_CA2_LO +: 3]);
  assign cb2_mode = dpp_pkg::dpp_ctl_mode_t'(
    ctrl_r[dpp_pkg::CTRL_CB2_LO +: 3]);
  assign ca2_is_out = ca2_mode[2];
  assign shift_on = |aux_r[dpp_pkg::AUX_SHIFT_LO +: 3];
  assign cb2_is_out = cb2_mode[2] || shift_on;
  assign ca1_edge = ctrl_r[dpp_pkg::CTRL_CA1_EDGE] ? rise[0] : fall[0];
  assign cb1_edge = ctrl_r[dpp_pkg::CTRL_CB1_EDGE] ? rise[2] : fall[2];
  assign ca2_edge = !ca2_is_out && (ca2_mode[1] ? rise[1] : fall[1]);
  assign cb2_edge = !cb2_is_out && (cb2_mode[1] ? rise[3] : fall[3]);

  // port A reads pins or latch
  dpp_port #(
    .W(dpp_pkg::PORT_W),
    .READ_OUT_REG(1'b0)
  ) u_port_a (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .pin_i(pa_s),
    .edge_i(ca1_edge),
    .latch_en_i(aux_r[dpp_pkg::AUX_LATCH_A]),
    .wr_out_i(wr && hit_a_any),
    .wr_dir_i(wr && register_select_lines_i == dpp_pkg::REG_DIR_A),
    .wdata_i(data_i),
    .rd_done_i(rd && hit_a_any),
    .dir_o(pa_dir),
    .out_o(pa_out),
    .rdata_o(pa_rd)
  );

  // port B keeps its latched value
  dpp_port #(
    .W(dpp_pkg::PORT_W),
    .READ_OUT_REG(1'b1)
  ) u_port_b (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .pin_i(pb_s),
    .edge_i(cb1_edge),
    .latch_en_i(aux_r[dpp_pkg::AUX_LATCH_B]),
    .wr_out_i(wr && hit_b),
    .wr_dir_i(wr && register_select_lines_i == dpp_pkg::REG_DIR_B),
    .wdata_i(data_i),
    .rd_done_i(1'b0),
    .dir_o(pb_dir),
    .out_o(pb_out),
    .rdata_o(pb_rd)
  );

  // flag set and clear, set wins
  always_comb begin
    flag_set = '0;
    flag_clr = '0;
    flag_set[dpp_pkg::FLAG_CA1] = ca1_edge;
    flag_set[dpp_pkg::FLAG_CA2] = ca2_edge;
    flag_set[dpp_pkg::FLAG_CB1] = cb1_edge;
    flag_set[dpp_pkg::FLAG_CB2] = cb2_edge;
    if (wr && register_select_lines_i == dpp_pkg::REG_FLAGS) begin
      flag_clr = data_i[6:0];
    end
    if ((rd || wr) && hit_a) begin
      flag_clr[dpp_pkg::FLAG_CA1] = 1'b1;
      flag_clr[dpp_pkg::FLAG_CA2] = !ca2_mode[0] || ca2_is_out;
    end
    if ((rd || wr) && hit_b) begin
      flag_clr[dpp_pkg::FLAG_CB1] = 1'b1;
      flag_clr[dpp_pkg::FLAG_CB2] = !cb2_mode[0] || cb2_is_out;
    end
  end

  always_comb begin
    aux_nxt = aux_r;
    ctrl_nxt = ctrl_r;
    flags_nxt = flags_r;
    enable_nxt = enable_r;
    if (ce_i) begin
      flags_nxt = ((flags_r & ~flag_clr) | flag_set) & dpp_pkg::FLAG_MASK;
      if (wr && register_select_lines_i == dpp_pkg::REG_AUX) begin
        aux_nxt = data_i;
      end
      if (wr && register_select_lines_i == dpp_pkg::REG_CTRL) begin
        ctrl_nxt = data_i;
      end
      if (wr && register_select_lines_i == dpp_pkg::REG_ENABLE) begin
        if (data_i[dpp_pkg::ENABLE_SET]) begin
          enable_nxt = enable_r | (data_i[6:0] & dpp_pkg::FLAG_MASK);
        end else begin
          enable_nxt = enable_r & ~data_i[6:0];
        end
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      aux_r <= dpp_pkg::RESET_BYTE;
      ctrl_r <= dpp_pkg::RESET_BYTE;
      flags_r <= '0;
      enable_r <= '0;
    end else begin
      aux_r <= aux_nxt;
      ctrl_r <= ctrl_nxt;
      flags_r <= flags_nxt;
      enable_r <= enable_nxt;
    end
  end

  always_comb begin
    ca2_lvl_nxt = ca2_lvl_r;
    cb2_lvl_nxt = cb2_lvl_r;
    cb1_lvl_nxt = cb1_lvl_r;
    timer_lvl_nxt = timer_lvl_r;
    if (ce_i) begin
      timer_lvl_nxt = timer_level_i;
      cb1_lvl_nxt = serial_clk_out_i;
      case (ca2_mode)
        dpp_pkg::CM_HANDSHAKE: begin
          if ((rd || wr) && hit_a) begin
            ca2_lvl_nxt = 1'b0;
          end else if (ca1_edge) begin
            ca2_lvl_nxt = 1'b1;
          end
        end
        dpp_pkg::CM_PULSE: ca2_lvl_nxt = !((rd || wr) && hit_a);
        dpp_pkg::CM_LOW: ca2_lvl_nxt = 1'b0;
        default: ca2_lvl_nxt = 1'b1;
      endcase
      if (shift_on) begin
        cb2_lvl_nxt = serial_data_out_i;
      end else begin
        case (cb2_mode)
          dpp_pkg::CM_HANDSHAKE: begin
            if (wr && hit_b) begin
              cb2_lvl_nxt = 1'b0;
            end else if (cb1_edge) begin
              cb2_lvl_nxt = 1'b1;
            end
          end
          dpp_pkg::CM_PULSE: cb2_lvl_nxt = !(wr && hit_b);
          dpp_pkg::CM_LOW: cb2_lvl_nxt = 1'b0;
          default: cb2_lvl_nxt = 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ca2_lvl_r <= 1'b1;
      cb2_lvl_r <= 1'b1;
      cb1_lvl_r <= 1'b0;
      timer_lvl_r <= 1'b0;
    end else begin
      ca2_lvl_r <= ca2_lvl_nxt;
      cb2_lvl_r <= cb2_lvl_nxt;
      cb1_lvl_r <= cb1_lvl_nxt;
      timer_lvl_r <= timer_lvl_nxt;
    end
  end

  assign irq_any = |(flags_r & enable_r);

  always_comb begin
    data_nxt = data_r;
    data_oe_nxt = data_oe_r;
    if (ce_i) begin
      data_oe_nxt = rd;
      data_nxt = dpp_pkg::RESET_BYTE;
      if (rd) begin
        case (register_select_lines_i)
          dpp_pkg::REG_PORT_B: data_nxt = pb_rd;
          dpp_pkg::REG_PORT_A: data_nxt = pa_rd;
          dpp_pkg::REG_PORT_A_QUIET: data_nxt = pa_rd;
          dpp_pkg::REG_DIR_B: data_nxt = pb_dir;
          dpp_pkg::REG_DIR_A: data_nxt = pa_dir;
          dpp_pkg::REG_AUX: data_nxt = aux_r;
          dpp_pkg::REG_CTRL: data_nxt = ctrl_r;
          dpp_pkg::REG_FLAGS: data_nxt = {irq_any, flags_r};
          dpp_pkg::REG_ENABLE: data_nxt = {1'b1, enable_r};
          default: data_nxt = dpp_pkg::RESET_BYTE;
        endcase
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      data_r <= dpp_pkg::RESET_BYTE;
      data_oe_r <= 1'b0;
    end else begin
      data_r <= data_nxt;
      data_oe_r <= data_oe_nxt;
    end
  end

  assign data_o = data_r;
  assign data_oe_o = data_oe_r;
  assign first_port_lines_o = pa_out;
  assign first_port_lines_oe_o = pa_dir;
  // timer may own port B bit 7
  always_comb begin
    second_port_lines_o = pb_out;
    second_port_lines_oe_o = pb_dir;
    if (aux_r[dpp_pkg::AUX_TIMER_OUT]) begin
      second_port_lines_o[dpp_pkg::TIMER_PIN] = timer_lvl_r;
      second_port_lines_oe_o[dpp_pkg::TIMER_PIN] = 1'b1;
    end
  end
  assign pulse_count_o = ce_i && live && pb6_d_r &&
    !pb_s[dpp_pkg::COUNT_PIN];
  assign first_port_handshake_line_o = ca2_lvl_r;
  assign first_port_handshake_line_oe_o = ca2_is_out;
  assign second_port_handshake_line_o = cb2_lvl_r;
  assign second_port_handshake_line_oe_o = cb2_is_out;
  // shift clock on port B strobe line
  assign second_port_strobe_line_o = cb1_lvl_r;
  assign second_port_strobe_line_oe_o = shift_on;
  assign serial_clk_in_o = ctl_s[2];
  assign serial_data_in_o = ctl_s[3];
  assign irq_n_o = 1'b0;
  assign irq_oe_o = irq_any;

  sequence s_a_access;
    ce_i && sel && hit_a && ca2_mode == dpp_pkg::CM_HANDSHAKE;
  endsequence

  sequence s_strobe_a;
    ce_i && ca1_edge && !(sel && hit_a);
  endsequence

  chk_irq_flag: assert property (
    @(posedge clock_i) disable iff (rst_i)
    ce_i && ca1_edge && enable_r[dpp_pkg::FLAG_CA1]
    && !(wr && register_select_lines_i == dpp_pkg::REG_ENABLE)
    |=> irq_oe_o && !irq_n_o)
    else $error("enabled flag did not raise interrupt");

  chk_flag_set: assert property (
    @(posedge clock_i) disable iff (rst_i)
    ce_i && cb1_edge |=> flags_r[dpp_pkg::FLAG_CB1])
    else $error("strobe edge lost its flag");

  chk_read_b: assert property (
    @(posedge clock_i) disable iff (rst_i)
    rd && hit_b |=> data_oe_o && data_o == $past(pb_rd))
    else $error("port B read returned wrong value");

  chk_dir_write: assert property (
    @(posedge clock_i) disable iff (rst_i)
    wr && register_select_lines_i == dpp_pkg::REG_DIR_A
    |=> first_port_lines_oe_o == $past(data_i))
    else $error("direction write did not reach pin enables");

  chk_no_select: assert property (
    @(posedge clock_i) disable iff (rst_i)
    ce_i && !sel |=> !data_oe_o)
    else $error("data driven while unselected");

  chk_hs_low: assert property (
    @(posedge clock_i) disable iff (rst_i)
    s_a_access ##1 (ca2_mode == dpp_pkg::CM_HANDSHAKE)
    |-> !first_port_handshake_line_o)
    else $error("handshake line not low after port access");

  chk_hs_release: assert property (
    @(posedge clock_i) disable iff (rst_i)
    s_strobe_a ##0 (ca2_mode == dpp_pkg::CM_HANDSHAKE)
    ##1 (ca2_mode == dpp_pkg::CM_HANDSHAKE)
    |-> first_port_handshake_line_o)
    else $error("strobe edge did not release handshake line");

  chk_reset_clear: assert property (
    @(posedge clock_i)
    rst_i |=> first_port_lines_oe_o == '0 && !irq_oe_o
    && second_port_lines_oe_o == '0)
    else $error("reset left a pin driven or interrupt on");
endmodule

/* tb/dpp_periph.sv */
// Peripheral model driving both ports and the strobe lines.
`timescale 1ns/1ns
module dpp_periph (
  input wire logic clock_i, // System clock.
  input wire logic [7:0] a_o_i, // Port A drive.
  input wire logic [7:0] a_oe_i, // Port A enables.
  input wire logic [7:0] b_o_i, // Port B drive.
  input wire logic [7:0] b_oe_i, // Port B enables.
  input wire logic [7:0] a_val_i, // Levels offered on port A.
  input wire logic [7:0] b_val_i, // Levels offered on port B.
  input wire logic [7:0] a_load_i, // Overloaded port A bits.
  input wire logic ready_i, // Requested strobe level.
  output logic [7:0] a_pin_o, // Port A wire level.
  output logic [7:0] b_pin_o, // Port B wire level.
  output logic strobe_o // Strobe to both ports.
);
  always_ff @(posedge clock_i) begin
    strobe_o <= ready_i;
  end
  // Heavy loads pull port A outputs to the opposite level.
  assign a_pin_o = (a_oe_i & (a_o_i ^ a_load_i)) | (~a_oe_i & a_val_i);
  assign b_pin_o = (b_oe_i & b_o_i) | (~b_oe_i & b_val_i);
endmodule

/* tb/dual_parallel_port_io_bench.sv */
// Self-checking bench for the dual parallel port.
`timescale 1ns/1ns
module dual_parallel_port_io_bench;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic cs_hi = 1'b0;
  logic cs_n = 1'b1;
  logic rw = 1'b1;
  logic ready = 1'b1;
  logic tmr = 1'b0;
  logic irq_oe;
  logic irq_n, doe, hs, hs_oe;
  logic strobe;
  logic [3:0] idx = 4'h0;
  logic [7:0] wd = 8'h00;
  logic [7:0] a_val = 8'h00;
  logic [7:0] b_val = 8'h00;
  logic [7:0] a_load = 8'h00;
  logic [7:0] rd, a_o, a_oe, b_o, b_oe, a_pin, b_pin;
  integer errors = 0;
  integer samples_checked = 0;
  integer cycles = 0;
  integer seed = 32'hB88ED7EE;

  always #20 clock_i = ~clock_i;

  dpp_top u_dpp_top (
    .clock_i(clock_i), .rst_i(rst_i), .ce_i(1'b1),
    .select_active_high_i(cs_hi), .select_active_low_n_i(cs_n),
    .rw_i(rw), .register_select_lines_i(idx), .data_i(wd),
    .data_o(rd), .data_oe_o(doe),
    .first_port_lines_i(a_pin), .first_port_lines_o(a_o),
    .first_port_lines_oe_o(a_oe), .second_port_lines_i(b_pin),
    .second_port_lines_o(b_o), .second_port_lines_oe_o(b_oe),
    .first_port_strobe_in_i(strobe),
    .first_port_handshake_line_i(1'b1),
    .first_port_handshake_line_o(hs),
    .first_port_handshake_line_oe_o(hs_oe),
    .second_port_strobe_line_i(strobe), .second_port_strobe_line_o(),
    .second_port_strobe_line_oe_o(),
    .second_port_handshake_line_i(1'b1),
    .second_port_handshake_line_o(), .second_port_handshake_line_oe_o(),
    .timer_level_i(tmr), .pulse_count_o(),
    .serial_clk_out_i(1'b0), .serial_data_out_i(1'b0),
    .serial_clk_in_o(), .serial_data_in_o(),
    .irq_n_o(irq_n), .irq_oe_o(irq_oe)
  );

  dpp_periph u_dpp_periph (
    .clock_i(clock_i), .a_o_i(a_o), .a_oe_i(a_oe), .b_o_i(b_o),
    .b_oe_i(b_oe), .a_val_i(a_val), .b_val_i(b_val),
    .a_load_i(a_load), .ready_i(ready), .a_pin_o(a_pin),
    .b_pin_o(b_pin), .strobe_o(strobe)
  );

  task automatic finish_test();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One access; read data is settled when the task returns.
  task automatic acc(input logic w, input logic [3:0] i, input logic [7:0] d);
    @(posedge clock_i);
    cs_hi <= 1'b1;
    cs_n <= 1'b0;
    rw <= ~w;
    idx <= i;
    wd <= d;
    @(posedge clock_i);
    cs_hi <= 1'b0;
    cs_n <= 1'b1;
    #1;
  endtask

  task automatic rchk(input logic [3:0] i, input logic [7:0] exp);
    acc(1'b0, i, 8'h00);
    check({7'h00, doe}, 8'h01);
    check(rd, exp);
  endtask

  task automatic settle();
    repeat (6) @(posedge clock_i);
    #1;
  endtask

  function automatic logic [7:0] mix(input logic [7:0] d, o, p);
    return (d & o) | (~d & p);
  endfunction

  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      finish_test();
    end
  end

  initial begin
    logic [7:0] d, o, v;
    repeat (3) @(posedge clock_i);
    rst_i <= 1'b0;
    rchk(4'h2, 8'h00);
    rchk(4'h3, 8'h00);
    check(a_oe | b_oe, 8'h00);
    rchk(4'h4, 8'h00);
    for (int k = 0; k < 24; k++) begin
      d = 8'($random(seed));
      o = 8'($random(seed));
      v = 8'($random(seed));
      @(posedge clock_i);
      b_val <= v;
      a_val <= ~v;
      a_load <= 8'($random(seed));
      acc(1'b1, 4'h3, 8'h00);
      acc(1'b1, 4'h1, o);
      check(a_oe, 8'h00);
      acc(1'b1, 4'h3, d);
      acc(1'b1, 4'h2, d);
      acc(1'b1, 4'h0, o);
      settle();
      check(b_oe, d);
      check(mix(d, b_o, 8'h00), mix(d, o, 8'h00));
      check(mix(d, a_o, 8'h00), mix(d, o, 8'h00));
      rchk(4'h0, mix(d, o, v));
      rchk(4'hF, mix(d, o ^ a_load, ~v));
    end
    acc(1'b1, 4'h3, 8'h00);
    acc(1'b1, 4'h2, 8'h00);
    acc(1'b1, 4'hB, 8'h03);
    acc(1'b1, 4'hC, 8'h00);
    acc(1'b1, 4'hE, 8'h92);
    @(posedge clock_i);
    a_val <= 8'hA5;
    b_val <= 8'h3C;
    settle();
    rchk(4'h1, 8'hA5);
    @(posedge clock_i);
    ready <= 1'b0;
    settle();
    check({6'h00, irq_n, irq_oe}, 8'h01);
    @(posedge clock_i);
    a_val <= 8'h5A;
    b_val <= 8'hC3;
    settle();
    rchk(4'h1, 8'hA5);
    rchk(4'h1, 8'h5A);
    rchk(4'hD, 8'h90);
    rchk(4'h0, 8'h3C);
    settle();
    check({7'h00, irq_oe}, 8'h00);
    acc(1'b1, 4'hB, 8'h80);
    @(posedge clock_i);
    tmr <= 1'b1;
    settle();
    check({6'h00, b_oe[7], b_o[7]}, 8'h03);
    // Port A handshake mode: an access lowers the line, a falling strobe edge
    // raises it again.
    acc(1'b1, 4'hC, 8'h08);
    rchk(4'h1, 8'h5A);
    check({6'h00, hs_oe, hs}, 8'h02);
    @(posedge clock_i);
    ready <= 1'b1;
    settle();
    check({6'h00, hs_oe, hs}, 8'h02);
    @(posedge clock_i);
    ready <= 1'b0;
    settle();
    check({6'h00, hs_oe, hs}, 8'h03);
    finish_test();
  end
endmodule
